//--- src/afesc_pkg.sv
package afesc_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int DIS_W  = 4;

  localparam logic [ADDR_W-1:0] ADDR_SETUP1    = 6'h01;
  localparam logic [ADDR_W-1:0] ADDR_SETUP2    = 6'h02;
  localparam logic [ADDR_W-1:0] ADDR_SETUP3    = 6'h03;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RST  = 6'h04;
  localparam logic [ADDR_W-1:0] ADDR_CYCLE_RST = 6'h05;

  localparam logic [DATA_W-1:0] SETUP1_RST  = 8'h03;
  localparam logic [DATA_W-1:0] SETUP2_RST  = 8'h20;
  localparam logic [DATA_W-1:0] SETUP3_RST  = 8'h1f;
  localparam logic [DATA_W-1:0] SETUP1_MASK = 8'h7f;
  localparam logic [DATA_W-1:0] SETUP2_MASK = 8'hef;
  localparam logic [DATA_W-1:0] SETUP3_MASK = 8'hff;
  localparam logic [DATA_W-1:0] RD_NONE     = 8'h00;

  localparam int S1_ENABLE   = 0;
  localparam int S1_DSAMPLE  = 1;
  localparam int S1_MONO     = 2;
  localparam int S1_SELECTIVE_POWERDOWN    = 3;
  localparam int S1_GOFS_LSB = 4;
  localparam int S1_MAXSPD   = 6;
  localparam int S2_FMT_LSB  = 0;
  localparam int S2_INVERT   = 2;
  localparam int S2_REFEXT   = 3;
  localparam int S2_RANGE    = 5;
  localparam int S2_LAT_LSB  = 6;
  localparam int S3_CODE_LSB = 0;
  localparam int S3_SHIFT_LSB = 4;
  localparam int S3_CHAN_LSB = 6;

  localparam logic [1:0] GOFS_POS   = 2'h2;
  localparam logic [1:0] GOFS_NEG   = 2'h3;
  localparam logic [1:0] SHIFT_ADV  = 2'h0;
  localparam logic [1:0] SHIFT_RET1 = 2'h2;
  localparam logic [1:0] SHIFT_RET2 = 2'h3;
  localparam logic [1:0] CHAN_RED   = 2'h0;

  localparam logic [1:0] ADC_DIV_NORMAL = 2'h2;
  localparam logic [1:0] ADC_DIV_FAST   = 2'h3;

  typedef enum logic [1:0] {CYC_RED, CYC_GREEN, CYC_BLUE} afesc_cycle_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } afesc_host_t;

  typedef struct packed {
    logic             power_on;
    logic [DIS_W-1:0] blocks_off;
    logic             double_sample_select;
    logic             mono;
    logic [1:0]       chan;
    logic             gain_ofs_pos;
    logic             gain_ofs_neg;
    logic             max_speed_select;
    logic [1:0]       output_format_select;
    logic             output_invert;
    logic             ref_dac_drive;
    logic             ref_dac_range;
    logic [3:0]       ref_dac_code;
    logic [3:0]       latency_mclk;
    logic             reset_advance;
    logic [1:0]       reset_retard;
    logic             clamp_pin_en;
    afesc_cycle_t     cycle_colour;
  } afesc_ctrl_t;

endpackage

//--- src/afesc_sync.sv
`timescale 1ns/10ps
module afesc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  import afesc_pkg::*;

  logic [W-1:0] meta_q;

  // Two stages; only the second stage feeds logic
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

//--- src/afesc_adc_div.sv
`timescale 1ns/10ps
module afesc_adc_div (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic fast,
  output logic      adc_en
);
  import afesc_pkg::*;

  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic       en_d;
  logic [1:0] div;

  always_comb begin
    div   = fast ? ADC_DIV_FAST : ADC_DIV_NORMAL;
    en_d  = (cnt_q == 2'h0);
    cnt_d = (cnt_q >= 2'(div - 2'h1)) ? 2'h0 : 2'(cnt_q + 2'h1);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 2'h0;
      adc_en <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      adc_en <= en_d;
    end
  end

  AST_ADC_GAP: assert property (@(posedge clock) disable iff (!rst_n)
    adc_en |=> !adc_en)
    else $error("adc enable pulses back to back");

endmodule

//--- src/afesc_regs.sv
// Function
// - Enable bit gates global power unless selective
// - Bit 1 picks single-ended or double sampling
// - Bit 2 picks colour or monochrome
// - Selective powerdown lets per-block disables act
// - Gain offset codes: zero, zero, +full, -full
// - Max speed bit set only in fastest mode
// - Output format: 14, 8+6, 7+7, 4+4+4+2
// - Invert bit flips output data polarity
// - External ref bit powers DAC off, Hi-Z
// - Ref DAC range: supply or top reference
// - Latency code adds ADC periods to output
// - ADC period is two clocks, three fast
// - Four-bit ref DAC code, default all ones
// - Reset sample shift: advance, nominal, retard
// - Monochrome channel: red, green, blue, reserved
// - Any soft reset write resets setup registers and colour
// - Cycle reset write returns colour to red
// - Row mode forces mono and red channel
// - Auto-cycle in row mode: pin pulses advance colour, no clamp
`timescale 1ns/10ps
module afesc_regs (
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire afesc_pkg::afesc_host_t  host_pins,
  input  wire logic                    row_sequential_mode,
  input  wire logic                    auto_cycle_enable,
  input  wire logic                    fast_line_mode,
  input  wire logic [afesc_pkg::DIS_W-1:0] block_disable_field,
  input  wire logic                    clamp_or_cycle_pin,
  output afesc_pkg::afesc_ctrl_t       ctrl,
  output logic [afesc_pkg::DATA_W-1:0] ctl_rdata,
  output logic                         soft_reset_pulse,
  output logic                         adc_clock_en
);
  import afesc_pkg::*;

  localparam int PIN_W = $bits(afesc_host_t) + DIS_W + 4;

  logic              rst_meta_q;
  logic              rst_n_q;
  logic [PIN_W-1:0]  pins_s;
  afesc_host_t       host_s;
  logic              row_s;
  logic              auto_s;
  logic              fast_s;
  logic [DIS_W-1:0]  disable_s;
  logic              cycle_pin_s;

  logic [DATA_W-1:0] setup_power_and_sampling_q;
  logic [DATA_W-1:0] setup_power_and_sampling_d;
  logic [DATA_W-1:0] setup_output_format_q;
  logic [DATA_W-1:0] setup_output_format_d;
  logic [DATA_W-1:0] setup_reference_and_channel_q;
  logic [DATA_W-1:0] setup_reference_and_channel_d;
  logic              wr_prev_q;
  logic              wr_prev_d;
  logic              pin_prev_q;
  logic              pin_prev_d;
  afesc_cycle_t      cyc_q;
  afesc_cycle_t      cyc_d;
  afesc_ctrl_t       ctrl_d;
  logic [DATA_W-1:0] rdata_d;
  logic              soft_d;

  logic              wr_evt;
  logic              soft_evt;
  logic              cyc_rst_evt;
  logic              auto_act;
  logic              pin_rise;

  function automatic logic [1:0] fld2(input logic [DATA_W-1:0] r, input int lsb);
    fld2 = r[lsb +: 2];
  endfunction

  function automatic logic [3:0] lat_mclk(input logic [1:0] code, input logic fast);
    logic [3:0] div;
    div      = fast ? {2'h0, ADC_DIV_FAST} : {2'h0, ADC_DIV_NORMAL};
    lat_mclk = 4'({2'h0, code} * div);
  endfunction

  // Release of the asynchronous reset is made synchronous here
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Host port and mode pins are asynchronous to the master clock
  afesc_sync #(
    .W (PIN_W)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_n_q),
    .d     ({host_pins, row_sequential_mode, auto_cycle_enable, fast_line_mode,
             block_disable_field, clamp_or_cycle_pin}),
    .q     (pins_s)
  );

  assign {host_s, row_s, auto_s, fast_s, disable_s, cycle_pin_s} = pins_s;

  afesc_adc_div u_div (
    .clock  (clock),
    .rst_n  (rst_n_q),
    .fast   (fast_s),
    .adc_en (adc_clock_en)
  );

  // Address and data must be stable while the strobe crosses over
  assign wr_evt      = host_s.wr & ~wr_prev_q;
  assign soft_evt    = wr_evt && (host_s.addr == ADDR_SOFT_RST);
  assign cyc_rst_evt = wr_evt && (host_s.addr == ADDR_CYCLE_RST);
  assign auto_act    = row_s & auto_s;
  assign pin_rise    = cycle_pin_s & ~pin_prev_q;

  always_comb begin
    setup_power_and_sampling_d    = setup_power_and_sampling_q;
    setup_output_format_d         = setup_output_format_q;
    setup_reference_and_channel_d = setup_reference_and_channel_q;
    wr_prev_d                     = host_s.wr;
    pin_prev_d                    = cycle_pin_s;
    if (soft_evt) begin
      setup_power_and_sampling_d    = SETUP1_RST;
      setup_output_format_d         = SETUP2_RST;
      setup_reference_and_channel_d = SETUP3_RST;
    end else if (wr_evt) begin
      case (host_s.addr)
        ADDR_SETUP1: begin
          setup_power_and_sampling_d = host_s.wdata & SETUP1_MASK;
        end
        ADDR_SETUP2: begin
          setup_output_format_d = host_s.wdata & SETUP2_MASK;
        end
        ADDR_SETUP3: begin
          setup_reference_and_channel_d = host_s.wdata & SETUP3_MASK;
        end
        default: begin
          setup_power_and_sampling_d = setup_power_and_sampling_q;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      setup_power_and_sampling_q    <= SETUP1_RST;
      setup_output_format_q         <= SETUP2_RST;
      setup_reference_and_channel_q <= SETUP3_RST;
      wr_prev_q                     <= 1'b0;
      pin_prev_q                    <= 1'b0;
    end else begin
      setup_power_and_sampling_q    <= setup_power_and_sampling_d;
      setup_output_format_q         <= setup_output_format_d;
      setup_reference_and_channel_q <= setup_reference_and_channel_d;
      wr_prev_q                     <= wr_prev_d;
      pin_prev_q                    <= pin_prev_d;
    end
  end

  // Colour auto-cycle; a reset in the same cycle as a pulse wins
  always_comb begin
    cyc_d = cyc_q;
    if (soft_evt || cyc_rst_evt) begin
      cyc_d = CYC_RED;
    end else if (auto_act && pin_rise) begin
      case (cyc_q)
        CYC_RED:   cyc_d = CYC_GREEN;
        CYC_GREEN: cyc_d = CYC_BLUE;
        default:   cyc_d = CYC_RED;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cyc_q <= CYC_RED;
    end else begin
      cyc_q <= cyc_d;
    end
  end

  always_comb begin
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic [1:0]        shift;
    s1     = setup_power_and_sampling_q;
    s2     = setup_output_format_q;
    s3     = setup_reference_and_channel_q;
    shift  = fld2(s3, S3_SHIFT_LSB);
    ctrl_d = '0;
    ctrl_d.power_on   = s1[S1_SELECTIVE_POWERDOWN] | s1[S1_ENABLE];
    ctrl_d.blocks_off = s1[S1_SELECTIVE_POWERDOWN] ? disable_s : '0;
    ctrl_d.double_sample_select = s1[S1_DSAMPLE];
    ctrl_d.mono = s1[S1_MONO] | row_s;
    ctrl_d.chan = row_s ? CHAN_RED : fld2(s3, S3_CHAN_LSB);
    ctrl_d.gain_ofs_pos = (fld2(s1, S1_GOFS_LSB) == GOFS_POS);
    ctrl_d.gain_ofs_neg = (fld2(s1, S1_GOFS_LSB) == GOFS_NEG);
    ctrl_d.max_speed_select     = s1[S1_MAXSPD];
    ctrl_d.output_format_select = fld2(s2, S2_FMT_LSB);
    ctrl_d.output_invert        = s2[S2_INVERT];
    // Drive is also dropped under full power-down
    ctrl_d.ref_dac_drive = ~s2[S2_REFEXT] & ctrl_d.power_on;
    ctrl_d.ref_dac_range = s2[S2_RANGE];
    ctrl_d.ref_dac_code  = s3[S3_CODE_LSB +: 4];
    ctrl_d.latency_mclk  = lat_mclk(fld2(s2, S2_LAT_LSB), fast_s);
    ctrl_d.reset_advance = (shift == SHIFT_ADV);
    ctrl_d.reset_retard  = (shift == SHIFT_RET1) ? 2'h1 :
                           (shift == SHIFT_RET2) ? 2'h2 : 2'h0;
    ctrl_d.clamp_pin_en  = ~auto_act;
    ctrl_d.cycle_colour  = cyc_q;
    case (host_s.addr)
      ADDR_SETUP1: rdata_d = s1;
      ADDR_SETUP2: rdata_d = s2;
      ADDR_SETUP3: rdata_d = s3;
      default:     rdata_d = RD_NONE;
    endcase
    soft_d = soft_evt;
  end

  always_ff @(posedge clock or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl             <= '0;
      ctl_rdata        <= RD_NONE;
      soft_reset_pulse <= 1'b0;
    end else begin
      ctrl             <= ctrl_d;
      ctl_rdata        <= rdata_d;
      soft_reset_pulse <= soft_d;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_q);

  AST_SOFT_DEFAULTS: assert property (
    soft_evt |=> setup_power_and_sampling_q == SETUP1_RST
      && setup_output_format_q == SETUP2_RST
      && setup_reference_and_channel_q == SETUP3_RST && cyc_q == CYC_RED
      && soft_reset_pulse)
    else $error("soft reset did not restore defaults");

  AST_WRITE_SAMPLE: assert property (
    wr_evt && host_s.addr == ADDR_SETUP1
      |=> ##1 ctrl.double_sample_select == $past(host_s.wdata[S1_DSAMPLE], 2))
    else $error("sampling style not taken from write");

  AST_GLOBAL_POWER: assert property (
    rst_n_q && !setup_power_and_sampling_q[S1_SELECTIVE_POWERDOWN]
      |=> ctrl.power_on == $past(setup_power_and_sampling_q[S1_ENABLE]))
    else $error("global power does not follow enable bit");

  AST_SELECTIVE: assert property (
    setup_power_and_sampling_q[S1_SELECTIVE_POWERDOWN]
      |=> ctrl.power_on && ctrl.blocks_off == $past(disable_s))
    else $error("selective powerdown not applied");

  AST_GAIN_NEG: assert property (
    fld2(setup_power_and_sampling_q, S1_GOFS_LSB) == GOFS_NEG
      |=> ctrl.gain_ofs_neg && !ctrl.gain_ofs_pos)
    else $error("gain offset code wrong");

  AST_REF_HIZ: assert property (
    setup_output_format_q[S2_REFEXT] |=> !ctrl.ref_dac_drive)
    else $error("reference DAC driven while external");

  AST_LATENCY: assert property (
    fld2(setup_output_format_q, S2_LAT_LSB) == 2'h3 && fast_s
      |=> ctrl.latency_mclk == 4'h9)
    else $error("latency count wrong in fast mode");

  AST_ROW_FORCE: assert property (
    row_s |=> ctrl.mono && ctrl.chan == CHAN_RED)
    else $error("row mode did not force mono red");

  AST_CYCLE_RESET: assert property (
    cyc_rst_evt |=> cyc_q == CYC_RED ##1 ctrl.cycle_colour == CYC_RED)
    else $error("cycle reset did not return to red");

  AST_CYCLE_WRAP: assert property (
    auto_act && pin_rise && !wr_evt && cyc_q == CYC_BLUE |=> cyc_q == CYC_RED)
    else $error("colour cycle did not wrap to red");

  AST_CLAMP_PIN: assert property (
    auto_act |=> !ctrl.clamp_pin_en)
    else $error("pin still used as clamp while cycling");

  AST_SOFT_PULSE_ONE: assert property (
    soft_reset_pulse |=> !soft_reset_pulse)
    else $error("soft reset pulse longer than one cycle");

  AST_MONO_CHAN: assert property (
    rst_n_q && !row_s |=> ctrl.chan == $past(fld2(setup_reference_and_channel_q, S3_CHAN_LSB)))
    else $error("monochrome channel not taken from register");

endmodule

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
  import afesc_pkg::*;

  logic              clock       = 1'b0;
  logic              arst_n      = 1'b0;
  afesc_host_t       host        = '0;
  logic              row_mode    = 1'b0;
  logic              auto_cyc    = 1'b0;
  logic              fast        = 1'b0;
  logic [DIS_W-1:0]  dis         = '0;
  logic              cyc_pin     = 1'b0;
  afesc_ctrl_t       ctrl;
  logic [DATA_W-1:0] rdata;
  logic              srst;
  logic              adc_en;
  int                num_errors  = 0;
  int                check_count = 0;
  int                srst_cnt    = 0;
  int                adc_cnt     = 0;

  always #25 clock = ~clock;

  afesc_regs u_afesc_regs (
    .clock               (clock),
    .arst_n              (arst_n),
    .host_pins           (host),
    .row_sequential_mode (row_mode),
    .auto_cycle_enable   (auto_cyc),
    .fast_line_mode      (fast),
    .block_disable_field (dis),
    .clamp_or_cycle_pin  (cyc_pin),
    .ctrl                (ctrl),
    .ctl_rdata           (rdata),
    .soft_reset_pulse    (srst),
    .adc_clock_en        (adc_en)
  );

  // Pulse counters; scenarios compare against a snapshot taken off the edge
  always @(posedge clock) begin
    if (srst === 1'b1) srst_cnt++;
    if (adc_en === 1'b1) adc_cnt++;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Address and data settle 3 clocks ahead, strobe held past the synchroniser
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.addr = a;
    host.wdata = d;
    cyc(3);
    host.wr = 1'b1;
    cyc(4);
    host.wr = 1'b0;
    cyc(4);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    host.addr = a;
    cyc(4);
    check($sformatf("rdata %h", a), rdata, exp);
  endtask

  task automatic pulse;
    cyc_pin = 1'b1;
    cyc(4);
    cyc_pin = 1'b0;
    cyc(4);
  endtask

  task automatic t_defaults;
    int base;
    base = srst_cnt;
    wr(ADDR_SOFT_RST, 8'h00);
    check("srst_pulses", 8'(srst_cnt - base), 8'h01);
    rd(ADDR_SETUP1, 8'h03);
    rd(ADDR_SETUP2, 8'h20);
    rd(ADDR_SETUP3, 8'h1f);
    rd(ADDR_SOFT_RST, 8'h00);
    rd(ADDR_CYCLE_RST, 8'h00);
    rd(6'h3f, 8'h00);
    check("power_on", 8'(ctrl.power_on), 8'h01);
    check("dsample", 8'(ctrl.double_sample_select), 8'h01);
    check("dac_code", 8'(ctrl.ref_dac_code), 8'h0f);
    check("advance", 8'(ctrl.reset_advance), 8'h00);
    check("retard", 8'(ctrl.reset_retard), 8'h00);
  endtask

  task automatic t_setup1;
    wr(ADDR_SETUP1, 8'h00);
    check("power_on", 8'(ctrl.power_on), 8'h00);
    check("dsample", 8'(ctrl.double_sample_select), 8'h00);
    dis = 4'h5;
    wr(ADDR_SETUP1, 8'h08);
    check("power_on", 8'(ctrl.power_on), 8'h01);
    check("blocks_off", 8'(ctrl.blocks_off), 8'h05);
    wr(ADDR_SETUP1, 8'h07);
    check("blocks_off", 8'(ctrl.blocks_off), 8'h00);
    check("mono", 8'(ctrl.mono), 8'h01);
    check("dsample", 8'(ctrl.double_sample_select), 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SETUP1, {2'b00, 2'(i), 4'h1});
      check("gain_pos", 8'(ctrl.gain_ofs_pos), 8'(i == 2));
      check("gain_neg", 8'(ctrl.gain_ofs_neg), 8'(i == 3));
    end
    wr(ADDR_SETUP1, 8'hc1);
    check("max_speed", 8'(ctrl.max_speed_select), 8'h01);
    rd(ADDR_SETUP1, 8'h41);
  endtask

  task automatic t_setup2;
    logic [7:0] d;
    int         base;
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 1'(i), 1'b1, 1'(i >> 1), 1'(i), 2'(i)};
      wr(ADDR_SETUP2, d);
      check("format", 8'(ctrl.output_format_select), 8'(i));
      check("invert", 8'(ctrl.output_invert), 8'(i & 1));
      check("dac_drive", 8'(ctrl.ref_dac_drive), 8'(i < 2));
      check("dac_range", 8'(ctrl.ref_dac_range), 8'(i & 1));
      check("latency", 8'(ctrl.latency_mclk), 8'(i * 2));
      rd(ADDR_SETUP2, d & 8'hef);
    end
    fast = 1'b1;
    cyc(6);
    check("latency", 8'(ctrl.latency_mclk), 8'h09);
    base = adc_cnt;
    cyc(30);
    check("adc_pulses", 8'(adc_cnt - base), 8'h0a);
    fast = 1'b0;
    cyc(6);
    check("latency", 8'(ctrl.latency_mclk), 8'h06);
    base = adc_cnt;
    cyc(30);
    check("adc_pulses", 8'(adc_cnt - base), 8'h0f);
  endtask

  task automatic t_setup3;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {2'(i), 2'(i), 4'(i * 5)};
      wr(ADDR_SETUP3, d);
      check("dac_code", 8'(ctrl.ref_dac_code), 8'(i * 5));
      check("advance", 8'(ctrl.reset_advance), 8'(i == 0));
      check("retard", 8'(ctrl.reset_retard), 8'(i < 2 ? 0 : i - 1));
      check("chan", 8'(ctrl.chan), 8'(i));
      rd(ADDR_SETUP3, d);
    end
  endtask

  // Colour walk also proves both strobes pull the sequence back to red
  task automatic t_row;
    int base;
    wr(ADDR_SETUP1, 8'h01);
    row_mode = 1'b1;
    cyc(6);
    check("mono", 8'(ctrl.mono), 8'h01);
    check("chan", 8'(ctrl.chan), 8'h00);
    check("clamp_en", 8'(ctrl.clamp_pin_en), 8'h01);
    pulse();
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_RED));
    auto_cyc = 1'b1;
    cyc(6);
    check("clamp_en", 8'(ctrl.clamp_pin_en), 8'h00);
    pulse();
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_GREEN));
    pulse();
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_BLUE));
    pulse();
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_RED));
    pulse();
    wr(ADDR_CYCLE_RST, 8'ha5);
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_RED));
    rd(ADDR_SETUP1, 8'h01);
    pulse();
    base = srst_cnt;
    wr(ADDR_SOFT_RST, 8'h5a);
    check("srst_pulses", 8'(srst_cnt - base), 8'h01);
    check("colour", 8'(ctrl.cycle_colour), 8'(CYC_RED));
    rd(ADDR_SETUP1, SETUP1_RST);
    rd(ADDR_SETUP2, SETUP2_RST);
    rd(ADDR_SETUP3, SETUP3_RST);
    row_mode = 1'b0;
    auto_cyc = 1'b0;
    cyc(6);
  endtask

  task automatic complete_run;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    complete_run();
  end

  initial begin
    cyc(5);
    arst_n = 1'b1;
    cyc(4);
    t_defaults();
    t_setup1();
    t_setup2();
    t_setup3();
    t_row();
    complete_run();
  end

endmodule
